// ===== src/ofu_top.sv
`timescale 1ns/1ps

// Behaviour
// - Words are 32 bits, bit 0 most significant, bit 31 least.
// - Word bit 0 is sign, bits 1-31 magnitude, negatives two's complement.
// - Doubleword joins even word n and word n+1 into 64 bits.
// - Upper halfword is bits 0-15, lower halfword bits 16-31.
// - Selected halfword is signed; its sign fills the upper 16 bits.
// - Bytes 0..3 occupy bits 0-7, 8-15, 16-23, 24-31.
// - Each byte is selectable and zero-extended as an unsigned value.
// - Short float: 1-bit sign, 7-bit biased exponent, 24-bit fraction.
// - Long float is 64 bits with a 56-bit fraction.
// - Each exponent step scales the fraction by sixteen.
// - Binary point sits left of the fraction, between bits 7 and 8.
// - Positive operands use an excess-64 exponent.
// - Negative fractions use the one's complement exponent field.
// - Normalized means the leading fraction hex digit is nonzero.

module ofu_top
    import ofu_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    input  wire logic                    req_valid,
    input  wire ofu_op_t                 req_op,
    input  wire logic [LANE_SEL_W-1:0]   req_lane,
    input  wire logic                    req_addr_odd,
    input  wire logic [0:WORD_W-1]       mem_word_n,
    input  wire logic [0:WORD_W-1]       mem_word_n1,
    output logic                         res_valid,
    output logic [0:WORD_W-1]            res_word,
    output logic [0:DWORD_W-1]           res_dword,
    output logic                         res_align_err,
    output logic                         fp_sign,
    output logic [0:FP_EXP_W-1]          fp_exp,
    output logic [0:FP_LFRAC_W-1]        fp_frac,
    output logic                         fp_normalized,
    output logic signed [FP_SCALE_W-1:0] fp_scale_bits
);

    ////////////////////////////////////////////////////////////////////////////
    // Lane helpers

    // Halfword lane pick with sign fill, reused for both lanes
    function automatic logic [0:WORD_W-1] half_ext(input logic [0:WORD_W-1] w,
                                                   input logic lower);
        logic [0:HALF_W-1] h;
        h = lower ? w[HALF_W +: HALF_W] : w[0 +: HALF_W];
        half_ext = {{HALF_W{h[0]}}, h};
    endfunction

    // Byte lane pick, always zero filled
    function automatic logic [0:WORD_W-1] byte_ext(input logic [0:WORD_W-1] w,
                                                   input logic [LANE_SEL_W-1:0] k);
        byte_ext = {{(WORD_W-BYTE_W){1'b0}}, w[k*BYTE_W +: BYTE_W]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Combinational selection

    logic [0:WORD_W-1]          word_next;
    logic [0:DWORD_W-1]         dword_next;
    logic                       pair_needed;
    logic                       fp_long;
    logic [0:DWORD_W-1]         fp_operand;
    logic                       split_sign;
    logic [0:FP_EXP_W-1]        split_exp;
    logic [0:FP_LFRAC_W-1]      split_frac;
    logic                       split_norm;
    logic signed [FP_SCALE_W-1:0] split_scale;
    logic                       take;

    assign take        = clk_en && req_valid;
    // Pairs must start on an even word, otherwise the pair is not formed
    assign pair_needed = (req_op == OFU_OP_DWORD) || (req_op == OFU_OP_FP_LONG);
    assign fp_long     = (req_op == OFU_OP_FP_LONG);
    // Word n always lands in bits 0-31, word n+1 in bits 32-63
    assign dword_next  = {mem_word_n, mem_word_n1};
    assign fp_operand  = fp_long ? dword_next : {mem_word_n, RST_WORD};

    // Single-word result by operand kind
    always_comb
    begin
        case (req_op)
            OFU_OP_WORD:  word_next = mem_word_n;
            OFU_OP_HALF:  word_next = half_ext(mem_word_n, req_lane[0]);
            OFU_OP_BYTE:  word_next = byte_ext(mem_word_n, req_lane);
            default:      word_next = mem_word_n;
        endcase
    end

    // Float field splitter, shared by short and long operands
    ofu_fp_split ofu_fp_split_i
    (
        .operand    (fp_operand),
        .is_long    (fp_long),
        .sign       (split_sign),
        .exp_field  (split_exp),
        .frac       (split_frac),
        .normalized (split_norm),
        .scale_bits (split_scale)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Result registers

    // Valid pulse one cycle after an accepted request
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n && clk_en)  // Reset too waits for an enabled edge
            res_valid <= 1'b0;
        else if (clk_en)
            res_valid <= req_valid;
    end

    // Alignment error travels with the result
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n && clk_en)
            res_align_err <= 1'b0;
        else if (clk_en)
            res_align_err <= req_valid && pair_needed && req_addr_odd;
    end

    // Integer results; an odd pair start leaves the doubleword untouched
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n && clk_en)
        begin
            res_word  <= RST_WORD;
            res_dword <= RST_DWORD;
        end
        else if (take)
        begin
            res_word <= word_next;
            if (!(pair_needed && req_addr_odd))
                res_dword <= dword_next;
        end
    end

    // Float fields held until the next short or even-address long float request
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n && clk_en)
        begin
            fp_sign       <= 1'b0;
            fp_exp        <= RST_EXP;
            fp_frac       <= RST_FRAC;
            fp_normalized <= 1'b0;
            fp_scale_bits <= RST_SCALE;
        end
        else if (take && ((req_op == OFU_OP_FP_SHRT) ||
                          (fp_long && !req_addr_odd)))
        begin
            fp_sign       <= split_sign;
            fp_exp        <= split_exp;
            fp_frac       <= split_frac;
            fp_normalized <= split_norm;
            fp_scale_bits <= split_scale;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_take(ofu_op_t k);
        clk_en && req_valid && req_op == k;
    endsequence

    sequence s_take_pair;
        s_take(OFU_OP_DWORD) ##0 !req_addr_odd;
    endsequence

    a_word_pass: assert property (s_take(OFU_OP_WORD) |=>
        res_valid && res_word == $past(mem_word_n))
        else $error("word result differs from addressed word");

    a_half_sign_fill: assert property (s_take(OFU_OP_HALF) |=>
        res_word[0:15] == {16{res_word[16]}})
        else $error("halfword sign not filled into upper bits");

    a_half_lane_pick: assert property (s_take(OFU_OP_HALF) |=>
        res_word[16:31] == ($past(req_lane[0]) ? $past(mem_word_n[16:31])
                                               : $past(mem_word_n[0:15])))
        else $error("wrong halfword lane selected");

    a_byte_zero_fill: assert property (s_take(OFU_OP_BYTE) |=>
        res_word[0:23] == 24'h000000 &&
        res_word[24:31] == $past(mem_word_n[req_lane*8 +: 8]))
        else $error("byte lane wrong or sign extended");

    a_pair_order: assert property (s_take_pair |=>
        res_dword[0:31] == $past(mem_word_n) &&
        res_dword[32:63] == $past(mem_word_n1) && !res_align_err)
        else $error("doubleword pair not formed in order");

    a_pair_odd_refused: assert property (s_take(OFU_OP_DWORD) ##0 req_addr_odd
        |=> res_align_err && $stable(res_dword))
        else $error("odd pair start not refused");

    a_short_fields: assert property (s_take(OFU_OP_FP_SHRT) |=>
        fp_sign == $past(mem_word_n[0]) &&
        fp_exp == $past(mem_word_n[1:7]) &&
        fp_frac[0:23] == $past(mem_word_n[8:31]) &&
        fp_frac[24:55] == 32'h0000_0000)
        else $error("short float fields misplaced");

    a_long_frac: assert property (s_take(OFU_OP_FP_LONG) ##0 !req_addr_odd
        |=> fp_frac == $past({mem_word_n[8:31], mem_word_n1}))
        else $error("long float fraction misplaced");

    a_norm_flag: assert property (res_valid && $past(clk_en) &&
        $past(req_op) == OFU_OP_FP_SHRT |->
        fp_normalized == ($past(mem_word_n[8:11]) != 4'h0))
        else $error("normalized flag disagrees with leading digit");

    a_exp_bias: assert property (s_take(OFU_OP_FP_SHRT) ##0
        !mem_word_n[0] |=> fp_scale_bits == 9'(($signed({2'b00, fp_exp}) - 64) * 4))
        else $error("excess-64 scale wrong for positive operand");

    a_exp_ones_comp: assert property (s_take(OFU_OP_FP_SHRT) ##0
        mem_word_n[0] |=> fp_scale_bits == 9'(($signed({2'b00, ~fp_exp}) - 64) * 4))
        else $error("negative operand exponent not one's complemented");

    a_freeze_hold: assert property (!clk_en |=>
        $stable(res_word) && $stable(fp_exp) && $stable(res_valid))
        else $error("state moved while clock enable low");

endmodule // ofu_top

// ===== inc/ofu_pkg.sv
package ofu_pkg;

    // Word geometry, bit 0 is the most significant position
    localparam int WORD_W    = 32;
    localparam int DWORD_W   = 64;
    localparam int HALF_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int LANE_SEL_W = 2;

    // Floating point field layout (operand bit numbers)
    localparam int FP_SIGN_POS  = 0;
    localparam int FP_EXP_POS   = 1;
    localparam int FP_EXP_W     = 7;
    localparam int FP_FRAC_POS  = 8;
    localparam int FP_SFRAC_W   = 24;
    localparam int FP_LFRAC_W   = 56;
    localparam int FP_DIGIT_W   = 4;
    localparam int FP_SCALE_W   = 9;

    // Excess-64 bias: flipping the top exponent bit removes it
    localparam logic [FP_EXP_W-1:0] FP_EXP_BIAS = 7'h40;

    // Values after reset
    localparam logic [0:WORD_W-1]     RST_WORD  = 32'h0000_0000;
    localparam logic [0:DWORD_W-1]    RST_DWORD = 64'h0000_0000_0000_0000;
    localparam logic [0:FP_EXP_W-1]   RST_EXP   = 7'h00;
    localparam logic [0:FP_LFRAC_W-1] RST_FRAC  = 56'h00_0000_0000_0000;
    localparam logic [FP_SCALE_W-1:0] RST_SCALE = 9'h000;

    // Latency from request to result, in ref_clk cycles
    localparam int RESULT_LAT = 1;

    // Operand kinds
    typedef enum logic [2:0]
    {
        OFU_OP_WORD    = 3'h0,
        OFU_OP_HALF    = 3'h1,
        OFU_OP_BYTE    = 3'h2,
        OFU_OP_DWORD   = 3'h3,
        OFU_OP_FP_SHRT = 3'h4,
        OFU_OP_FP_LONG = 3'h5
    } ofu_op_t;

endpackage

// ===== src/ofu_fp_split.sv
`timescale 1ns/1ps

module ofu_fp_split
    import ofu_pkg::*;
(
    input  wire logic [0:DWORD_W-1]    operand,
    input  wire logic                  is_long,
    output logic                       sign,
    output logic [0:FP_EXP_W-1]        exp_field,
    output logic [0:FP_LFRAC_W-1]      frac,
    output logic                       normalized,
    output logic signed [FP_SCALE_W-1:0] scale_bits
);

    logic [FP_EXP_W-1:0] pos_exp;
    logic [FP_EXP_W-1:0] true_exp;

    // Leading hex digit test, shared shape for both widths
    function automatic logic lead_digit_set(input logic [0:FP_LFRAC_W-1] f);
        lead_digit_set = |f[0:FP_DIGIT_W-1];
    endfunction

    // Field split; short fraction sits left-aligned, low digits zero
    always_comb
    begin
        sign      = operand[FP_SIGN_POS];
        exp_field = operand[FP_EXP_POS +: FP_EXP_W];
        if (is_long)
            frac = operand[FP_FRAC_POS +: FP_LFRAC_W];
        else
            frac = {operand[FP_FRAC_POS +: FP_SFRAC_W],
                    {(FP_LFRAC_W-FP_SFRAC_W){1'b0}}};
    end

    // Negative fractions carry the one's complement exponent
    assign pos_exp    = sign ? ~exp_field : exp_field;
    // Excess-64 to two's complement is a flip of the top bit
    assign true_exp   = pos_exp ^ FP_EXP_BIAS;
    // One exponent step moves the binary point four places
    assign scale_bits = {true_exp[FP_EXP_W-1], true_exp, 1'b0} <<< 1;
    assign normalized = lead_digit_set(frac);

endmodule // ofu_fp_split

// ===== dv/ofu_mem_model.sv
`timescale 1ns/1ps

// Memory side: hands out the addressed word and the next one of its pair
module ofu_mem_model
    import ofu_pkg::*;
(
    input  wire logic              sel,
    input  wire logic [3:0]        addr,
    output logic      [0:WORD_W-1] word_n,
    output logic      [0:WORD_W-1] word_n1,
    output logic                   addr_odd
);
    logic [0:WORD_W-1] mem [0:15];

    // Unselected lines show the inverse so stale data never passes for valid
    always_comb
    begin
        word_n   = sel ? mem[addr] : ~mem[addr];
        word_n1  = sel ? mem[addr + 4'h1] : ~mem[addr + 4'h1];
        addr_odd = addr[0];
    end
endmodule // ofu_mem_model

// ===== dv/tb_operand_format_unit.sv
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end

module tb_operand_format_unit
    import ofu_pkg::*;
;
    typedef struct {
        ofu_op_t op; logic [0:WORD_W-1] word; logic [0:DWORD_W-1] dword; logic err;
        logic sign; logic [0:FP_EXP_W-1] exp; logic [0:FP_LFRAC_W-1] frac; logic norm;
        logic signed [FP_SCALE_W-1:0] scale;
    } ofu_exp_t;

    logic ref_clk, rst_n, req_valid, req_addr_odd, res_valid, res_align_err;
    logic clk_en = 1'b1;
    ofu_op_t req_op;
    logic [1:0] req_lane;
    logic [3:0] addr;
    logic [0:WORD_W-1] mem_word_n, mem_word_n1, res_word;
    logic [0:DWORD_W-1] res_dword;
    logic fp_sign, fp_normalized, en_seen, rnd_en;
    logic [0:FP_EXP_W-1] fp_exp;
    logic [0:FP_LFRAC_W-1] fp_frac;
    logic signed [FP_SCALE_W-1:0] fp_scale_bits;
    ofu_exp_t exp_q[$];
    ofu_exp_t held, mon_e;
    int fails, checks;

    ofu_mem_model ofu_mem_model_i (.sel(req_valid), .addr(addr), .word_n(mem_word_n),
        .word_n1(mem_word_n1), .addr_odd(req_addr_odd));

    ofu_top ofu_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .req_valid(req_valid), .req_op(req_op), .req_lane(req_lane),
        .req_addr_odd(req_addr_odd), .mem_word_n(mem_word_n), .mem_word_n1(mem_word_n1),
        .res_valid(res_valid), .res_word(res_word), .res_dword(res_dword),
        .res_align_err(res_align_err), .fp_sign(fp_sign), .fp_exp(fp_exp),
        .fp_frac(fp_frac), .fp_normalized(fp_normalized), .fp_scale_bits(fp_scale_bits));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a clock enable that drops at random during the stall test
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) clk_en <= rnd_en ? ($urandom_range(3, 0) != 0) : 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Driver: note the expected result, then hold the request until an enabled edge
    task automatic issue(input ofu_op_t op, input logic [1:0] lane, input logic [3:0] a);
        ofu_exp_t e;
        logic [0:WORD_W-1] w, w1;
        logic [FP_EXP_W-1:0] pe;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_op = op;
        req_lane = lane;
        addr = a;
        w = ofu_mem_model_i.mem[a];
        w1 = ofu_mem_model_i.mem[a + 4'h1];
        e = held;
        e.op = op;
        e.err = (op == OFU_OP_DWORD || op == OFU_OP_FP_LONG) && a[0];
        case (op)
            OFU_OP_HALF: e.word = lane[0] ? {{16{w[16]}}, w[16:31]} : {{16{w[0]}}, w[0:15]};
            OFU_OP_BYTE: e.word = {24'h000000, w[8*lane +: 8]};
            default:     e.word = w;
        endcase
        if (!e.err)
            e.dword = {w, w1};
        if (op == OFU_OP_FP_SHRT || (op == OFU_OP_FP_LONG && !a[0]))
        begin
            e.sign = w[0];
            e.exp = w[1:7];
            e.frac = (op == OFU_OP_FP_LONG) ? {w[8:31], w1} : {w[8:31], 32'h00000000};
            e.norm = (e.frac[0:3] != 4'h0);
            pe = w[0] ? ~w[1:7] : w[1:7];
            e.scale = 9'(4 * (int'(pe) - 64));
        end
        held = e;
        exp_q.push_back(e);
        @(posedge ref_clk);
        while (!clk_en) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: a result counts only after an edge that really ran
    always @(posedge ref_clk) en_seen <= clk_en && rst_n;

    always @(negedge ref_clk)
    begin
        if (res_valid && en_seen)
        begin
            if (exp_q.size() == 0)
            begin
                fails++;
                $display("ERROR %0t: result with nothing expected", $time);
            end
            else
            begin
                mon_e = exp_q.pop_front();
                if (mon_e.op inside {OFU_OP_WORD, OFU_OP_HALF, OFU_OP_BYTE})
                    `CHK(res_word, mon_e.word)
                `CHK(res_align_err, mon_e.err)
                `CHK(res_dword, mon_e.dword)
                `CHK(fp_sign, mon_e.sign)
                `CHK(fp_exp, mon_e.exp)
                `CHK(fp_frac, mon_e.frac)
                `CHK(fp_normalized, mon_e.norm)
                `CHK(fp_scale_bits, mon_e.scale)
            end
        end
    end

    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog, about ten times the few hundred cycles the tests need
    initial
    begin
        #50us;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(32'h519e));
        rst_n = 1'b0;
        rnd_en = 1'b0;
        req_valid = 1'b0;
        req_op = OFU_OP_WORD;
        req_lane = 2'h0;
        addr = 4'h0;
        held = '{OFU_OP_WORD, RST_WORD, RST_DWORD, 1'b0, 1'b0, RST_EXP, RST_FRAC, 1'b0, RST_SCALE};
        for (int i = 0; i < 16; i++)
            ofu_mem_model_i.mem[i] = $urandom;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        `CHK(res_valid, 1'b0)
        `CHK(res_dword, RST_DWORD)
        `CHK(fp_scale_bits, RST_SCALE)
        $display("test reset done");
        // Memory is loaded off the edge, never while the design samples it
        ofu_mem_model_i.mem[0] = 32'h12348001;
        ofu_mem_model_i.mem[2] = 32'h43100000;
        ofu_mem_model_i.mem[4] = 32'hbda0b000;
        ofu_mem_model_i.mem[6] = 32'h44010000;
        ofu_mem_model_i.mem[8] = 32'h435f5000;
        ofu_mem_model_i.mem[9] = 32'h00000001;
        ofu_mem_model_i.mem[10] = 32'hbfa0b000;
        // Odd pair straight after reset: refused, held values still zero
        issue(OFU_OP_FP_LONG, 2'h0, 4'h1);
        issue(OFU_OP_HALF, 2'h1, 4'h0);
        for (int i = 2; i < 12; i += 2)
            issue(OFU_OP_FP_SHRT, 2'h0, 4'(i));
        issue(OFU_OP_FP_LONG, 2'h0, 4'h8);
        $display("test directed done");
        // Every kind, every lane, even and odd address, back to back
        for (int o = 0; o < 6; o++)
            for (int l = 0; l < 4; l++)
                for (int a = 0; a < 2; a++)
                    issue(ofu_op_t'(3'(o)), 2'(l), 4'(a + 2 * l));
        $display("test sweep done");
        repeat (200)
            issue(ofu_op_t'(3'($urandom_range(5, 0))), 2'($urandom), 4'($urandom));
        $display("test random done");
        rnd_en = 1'b1;
        repeat (100)
            issue(ofu_op_t'(3'($urandom_range(5, 0))), 2'($urandom), 4'($urandom));
        @(negedge ref_clk);
        req_valid = 1'b0;
        rnd_en = 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK(exp_q.size(), 0)
        $display("test stall done");
        print_verdict();
    end
endmodule // tb_operand_format_unit
